/* File: bench/ca_ctrl_model.sv */
/* controller side model: drives chip select, cke and frames.
   assumes the bench raises req for one cycle per command. */
`default_nettype none
module ca_ctrl_model (
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  req,
  input  wire logic                  req_bad,
  input  wire logic                  req_cke,
  input  wire ca_parity_pkg::frame_t req_frame,
  input  wire logic                  alert_n,
  output logic                       cs_n,
  output logic                       cke,
  output ca_parity_pkg::frame_t      frame
);
  timeunit 1ns;
  timeprecision 1ps;
  import ca_parity_pkg::*;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cs_n <= 1'b1;
      cke <= 1'b1;
      frame <= '0;
    end else if (req && alert_n) begin
      cs_n <= 1'b0;
      cke <= req_cke;
      frame <= {(^req_frame[25:3]) ^ req_bad, req_frame[25:0]};
    end else begin
      cs_n <= 1'b1;
      cke <= 1'b1;
      // deselected lines must not keep showing the last command
      frame <= ~frame;
    end
  end
endmodule
`default_nettype wire

/* File: bench/ca_parity_check_and_error_log_tb.sv */
/* self-checking bench for the parity checker and error log.
   commands go through ca_ctrl_model; the checker is bound below. */
`default_nettype none
module ca_parity_check_and_error_log_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ca_parity_pkg::*;
  logic       clk_sys, rst, ce, req, req_bad, req_cke, crc, cs_n, cke;
  logic       alert_n, exec_valid, precharge_all, pde, readout_valid;
  logic       status, checking;
  frame_t     req_frame, frame, exec_frame;
  logic [7:0] readout_data, mode_dly;
  logic [6:0] wl, rl;
  logic [2:0] pl;
  int         n_mismatch, samples_checked;
  frame_t     probe;
  assign probe = '{act_n: 1'b1, ba: 2'h2, default: '0};

  ca_ctrl_model ctrl (.clk_sys, .rst, .req, .req_bad, .req_cke,
    .req_frame, .alert_n, .cs_n, .cke, .frame);
  ca_parity_check_and_error_log dut (.clk_sys, .rst, .ce, .cs_n,
    .cke, .frame, .crc_error_status(crc), .additive_latency(5'h03),
    .read_cas_latency(5'h0b), .write_cas_latency(5'h09), .alert_n,
    .exec_valid, .exec_frame, .precharge_all, .power_down_entry(pde),
    .readout_valid, .readout_data, .write_latency(wl), .read_latency(rl),
    .parity_mode_delay(mode_dly), .parity_error_status(status),
    .parity_latency(pl), .checking);

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic frame_t mk(logic [3:0] c, logic [2:0] s,
                                logic [13:0] a);
    mk = '0;
    {mk.act_n, mk.ras, mk.cas, mk.we} = c;
    {mk.bg[0], mk.ba} = s;
    mk.addr = a;
  endfunction
  task automatic send(frame_t f, logic b, logic k);
    @(posedge clk_sys);
    req <= 1'b1;
    req_frame <= f;
    req_bad <= b;
    req_cke <= k;
    @(posedge clk_sys);
    req <= 1'b0;
  endtask
  task automatic lat(output int n);
    #1 n = 0;
    while (exec_valid !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      #1 n++;
    end
  endtask
  // looks just after each edge so the registered alert has settled
  task automatic wait_alert(logic lvl);
    #1;
    for (int i = 0; i < 30 && alert_n !== lvl; i++) begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  // long wait keeps the mode update delay with latency up to 8
  task automatic mr5(logic [2:0] c, logic p);
    send(mk(4'h8, 3'h5, {4'h0, p, 6'h00, c}), 1'b0, 1'b1);
    repeat (34) @(posedge clk_sys);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_basic;
    int n;
    chk({alert_n, status, checking, 2'b0, pl}, 8'ha0);
    send(probe, 1'b1, 1'b1);
    lat(n);
    chk(8'(n), 8'h00);
    // a frozen clock enable must swallow a mode register write
    @(posedge clk_sys);
    ce <= 1'b0;
    send(mk(4'h8, 3'h5, 14'h0001), 1'b0, 1'b1);
    repeat (2) @(posedge clk_sys);
    ce <= 1'b1;
    #1 chk({5'h00, pl}, 8'h00);
    $display("test basic done");
  endtask
  task automatic t_latency;
    int n;
    logic [7:0] cl [1:4];
    cl = '{8'h04, 8'h05, 8'h06, 8'h08};
    for (int c = 1; c <= 4; c++) begin
      mr5(3'(c), 1'b0);
      chk(mode_dly, 8'h18 + cl[c]);
      chk({1'b0, wl}, 8'h0c + cl[c]);
      chk({1'b0, rl}, 8'h0e + cl[c]);
      send(probe, 1'b0, 1'b1);
      lat(n);
      chk(8'(n), cl[c]);
      mr5(3'h0, 1'b0);
      chk(mode_dly, 8'h18 + cl[c]);
    end
    $display("test latency done");
  endtask
  task automatic t_error;
    int n;
    mr5(3'h1, 1'b0);
    crc <= 1'b1;
    send(probe, 1'b1, 1'b1);
    wait_alert(1'b0);
    chk({status, checking}, 8'h02);
    wait_alert(1'b1);
    send(probe, 1'b1, 1'b1);
    lat(n);
    chk({alert_n, 7'(n)}, 8'h84);
    send(mk(4'hd, 3'h3, 14'h0), 1'b0, 1'b1);
    lat(n);
    @(posedge clk_sys);
    #1 chk(readout_valid, 8'h00);
    send(mk(4'h8, 3'h3, 14'h5), 1'b0, 1'b1);
    repeat (34) @(posedge clk_sys);
    send(mk(4'hd, 3'h3, 14'h0), 1'b0, 1'b1);
    lat(n);
    @(posedge clk_sys);
    #1 chk(readout_valid, 8'h01);
    chk(readout_data, 8'hc8);
    send(mk(4'hd, 3'h2, 14'h0), 1'b0, 1'b1);
    lat(n);
    @(posedge clk_sys);
    #1 chk(readout_data, 8'hc8);
    mr5(3'h1, 1'b0);
    chk({status, checking}, 8'h01);
    $display("test error done");
  endtask
  task automatic t_persist;
    mr5(3'h1, 1'b1);
    send(probe, 1'b1, 1'b1);
    wait_alert(1'b0);
    wait_alert(1'b1);
    chk(checking, 8'h01);
    send(mk(4'h9, 3'h0, 14'h0), 1'b1, 1'b0);
    wait_alert(1'b0);
    chk({alert_n, pde}, 8'h01);
    wait_alert(1'b1);
    chk(checking, 8'h01);
    $display("test persist done");
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    {rst, req_cke} = 2'b11;
    {req, req_bad, crc} = 3'h0;
    ce = 1'b1;
    req_frame = '0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_basic();
    t_latency();
    t_error();
    t_persist();
    report_and_stop();
  end
  // whole run needs about 540 cycles
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop();
  end
endmodule

bind ca_parity_check_and_error_log ca_parity_monitor mon (.clk_sys, .rst,
  .ce, .cs_n, .frame, .additive_latency, .write_cas_latency, .alert_n,
  .exec_valid, .exec_frame, .precharge_all, .readout_valid,
  .write_latency, .parity_error_status, .parity_latency, .checking);
`default_nettype wire

/* File: bench/ca_parity_monitor.sv */
/* port checker for ca_parity_check_and_error_log.
   bound into the design from the bench top file. */
`default_nettype none
module ca_parity_monitor (
  input wire logic                  clk_sys,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic                  cs_n,
  input wire ca_parity_pkg::frame_t frame,
  input wire logic [4:0]            additive_latency,
  input wire logic [4:0]            write_cas_latency,
  input wire logic                  alert_n,
  input wire logic                  exec_valid,
  input wire ca_parity_pkg::frame_t exec_frame,
  input wire logic                  precharge_all,
  input wire logic                  readout_valid,
  input wire logic [6:0]            write_latency,
  input wire logic                  parity_error_status,
  input wire logic [2:0]            parity_latency,
  input wire logic                  checking
);
  timeunit 1ns;
  timeprecision 1ps;
  import ca_parity_pkg::*;
  logic [6:0] wl_exp;
  always_comb begin
    case (parity_latency)
      3'h1: wl_exp = 7'h4;
      3'h2: wl_exp = 7'h5;
      3'h3: wl_exp = 7'h6;
      3'h4: wl_exp = 7'h8;
      default: wl_exp = 7'h0;
    endcase
    wl_exp = wl_exp + 7'(additive_latency) + 7'(write_cas_latency);
  end
  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  alert_status_a: assert property (
    $fell(alert_n) |-> parity_error_status && !checking)
    else $error("alert without status or with checking on");
  alert_wide_a: assert property ($fell(alert_n) |-> !alert_n[*8])
    else $error("alert pulse too short");
  alert_end_a: assert property ($fell(alert_n) |-> ##[8:12] alert_n)
    else $error("alert pulse too long");
  precharge_a: assert property (
    $fell(alert_n) |-> ##[1:12] precharge_all)
    else $error("no precharge all after error");
  passthru_a: assert property (
    ce && parity_latency == 3'h0 && !cs_n && alert_n
    |-> exec_valid && exec_frame == frame)
    else $error("command not passed through with latency off");
  // registered one cycle behind, so skip the edge right after reset
  latency_sum_a: assert property (
    !$past(rst) && $past(ce) |-> write_latency == $past(wl_exp))
    else $error("write latency sum wrong");
  readout_src_a: assert property (
    readout_valid |-> $past(exec_valid) && $past(exec_frame.ras)
    && !$past(exec_frame.cas))
    else $error("readout without executed read");
  check_resume_a: assert property (
    $fell(parity_error_status) |-> ##[0:2] checking)
    else $error("checking not resumed after clear");
endmodule
`default_nettype wire

/* File: rtl/ca_cmd_delay.sv */
/*
 * Command delay line: holds accepted frames and releases each one
 * after the programmed number of clocks, or at once when zero.
 * Assumes the delay only changes while the line is empty.
 */
`default_nettype none
module ca_cmd_delay
  import ca_parity_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  input  wire logic                ce,
  input  wire logic [3:0]          delay_clks,
  input  wire logic                in_valid,
  input  wire ca_parity_pkg::frame_t in_frame,
  output logic                     out_valid,
  output ca_parity_pkg::frame_t    out_frame
);
  import ca_parity_pkg::*;

  logic   vld_r [0:7];
  frame_t frm_r [0:7];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        vld_r[i] <= 1'b0;
        frm_r[i] <= '0;
      end
    end else if (ce) begin
      // zero delay bypasses the line; a frame caught here would replay
      // once the latency is switched on
      vld_r[0] <= in_valid && (delay_clks != 4'h0);
      frm_r[0] <= in_frame;
      for (int i = 1; i < 8; i++) begin
        vld_r[i] <= vld_r[i-1];
        frm_r[i] <= frm_r[i-1];
      end
    end
  end

  // tap at delay-1 gives exactly delay clocks to the output
  always_comb begin
    if (delay_clks == 4'h0) begin
      out_valid = in_valid;
      out_frame = in_frame;
    end else begin
      out_valid = vld_r[3'(delay_clks - 4'h1)];
      out_frame = frm_r[3'(delay_clks - 4'h1)];
    end
  end

endmodule
`default_nettype wire

/* File: rtl/ca_parity_check_and_error_log.sv */
/*
 * Command/address parity checker with error log readout.
 * Frames arrive from controller logic on clk_sys, so no synchroniser.
 * Executed commands leave through exec_*; array and data path
 * timing beyond the parity delay belong to other blocks.
 */
`include "ca_parity_defines.svh"
`default_nettype none
module ca_parity_check_and_error_log
  import ca_parity_pkg::*;
(
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  cs_n,
  input  wire logic                  cke,
  input  wire ca_parity_pkg::frame_t frame,
  input  wire logic                  crc_error_status,
  input  wire logic [4:0]            additive_latency,
  input  wire logic [4:0]            read_cas_latency,
  input  wire logic [4:0]            write_cas_latency,
  output logic                       alert_n,
  output logic                       exec_valid,
  output ca_parity_pkg::frame_t      exec_frame,
  output logic                       precharge_all,
  output logic                       power_down_entry,
  output logic                       readout_valid,
  output logic [7:0]                 readout_data,
  output logic [6:0]                 write_latency,
  output logic [6:0]                 read_latency,
  output logic [7:0]                 parity_mode_delay,
  output logic                       parity_error_status,
  output logic [2:0]                 parity_latency,
  output logic                       checking
);
  import ca_parity_pkg::*;

  localparam logic [3:0] ALERT_PW = 4'(`ALERT_PW_CYC);

  //**********************************************************
  // mode register state
  //**********************************************************
  logic [2:0]  pl_r;
  logic [2:0]  pl_prev_r;
  logic        persist_r;
  logic        status_r;
  logic        readout_en_r;
  logic [1:0]  page_r;
  logic [3:0]  pl_clks;
  chk_state_t  state_r;
  chk_state_t  state_nxt;
  logic [3:0]  alert_cnt_r;
  logic [7:0]  log_r [0:3];

  logic        dly_valid;
  frame_t      dly_frame;
  logic        cmd_mrs;
  logic        cmd_read;
  logic        cmd_sre;
  logic        par_err;
  logic        accept;
  logic [2:0]  mr_sel;

  assign pl_clks = pl_clocks(pl_r);

  //**********************************************************
  // parity check
  //**********************************************************
  // even parity over the whole frame; chip id is outside it
  assign par_err = !cs_n && (pl_r != `PL_OFF) && (state_r == ST_CHECK)
                && ^{frame.par, frame.act_n, frame.ras, frame.cas,
                     frame.we, frame.bg, frame.ba, frame.a17,
                     frame.addr};

  // refresh with cke low is a self refresh entry
  assign cmd_sre = frame.act_n && !frame.ras && !frame.cas && frame.we
                && !cke;

  // nothing is taken while the alert window runs
  assign accept = !cs_n && !par_err && (state_r != ST_ALERT);

  //**********************************************************
  // command delay
  //**********************************************************
  ca_cmd_delay u_delay (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .ce         (ce),
    .delay_clks (pl_clks),
    .in_valid   (accept),
    .in_frame   (frame),
    .out_valid  (dly_valid),
    .out_frame  (dly_frame)
  );

  assign exec_valid = dly_valid;
  assign exec_frame = dly_frame;

  assign cmd_mrs = dly_valid && dly_frame.act_n && !dly_frame.ras
                && !dly_frame.cas && !dly_frame.we;
  assign cmd_read = dly_valid && dly_frame.act_n && dly_frame.ras
                 && !dly_frame.cas && dly_frame.we;
  assign mr_sel = {dly_frame.bg[0], dly_frame.ba};

  //**********************************************************
  // mode register writes
  //**********************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pl_r      <= `PL_OFF;
      pl_prev_r <= `PL_OFF;
      persist_r <= 1'b0;
    end else if (ce && cmd_mrs && mr_sel == `MR_SEL_FIVE) begin
      pl_r      <= dly_frame.addr[`MR5_PL_LSB +: 3];
      pl_prev_r <= pl_r;
      persist_r <= dly_frame.addr[`MR5_PERSIST_BIT];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readout_en_r <= 1'b0;
      page_r       <= 2'h0;
    end else if (ce && cmd_mrs && mr_sel == `MR_SEL_THREE) begin
      readout_en_r <= dly_frame.addr[`MR3_READOUT_BIT];
      page_r       <= dly_frame.addr[`MR3_PAGE_LSB +: 2];
    end
  end

  // a new error wins over a clear; writing one is simply blocked
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_r <= 1'b0;
    end else if (ce) begin
      if (par_err) begin
        status_r <= 1'b1;
      end else if (cmd_mrs && mr_sel == `MR_SEL_FIVE
                   && !dly_frame.addr[`MR5_STATUS_BIT]) begin
        status_r <= 1'b0;
      end
    end
  end

  //**********************************************************
  // error log
  //**********************************************************
  // only the first error is kept until the status is cleared
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        log_r[i] <= 8'h00;
      end
    end else if (ce && par_err && !status_r) begin
      log_r[0] <= frame.addr[7:0];
      log_r[1] <= {frame.cas, frame.we, frame.addr[13:8]};
      log_r[2] <= {frame.par, frame.act_n, frame.bg[1], frame.bg[0],
                   frame.ba[1], frame.ba[0], frame.a17, frame.ras};
      log_r[3] <= {crc_error_status, 1'b1, pl_r, frame.cid};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      readout_valid <= 1'b0;
      readout_data  <= 8'h00;
    end else if (ce) begin
      readout_valid <= cmd_read && readout_en_r
                    && page_r == `READOUT_PAGE_LOG;
      if (dly_frame.ba == 2'h3) begin
        readout_data <= {log_r[3][7], status_r, log_r[3][5:0]};
      end else begin
        readout_data <= log_r[dly_frame.ba];
      end
    end
  end

  //**********************************************************
  // alert and recovery sequence
  //**********************************************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_CHECK: begin
        if (par_err) begin
          state_nxt = ST_ALERT;
        end
      end
      ST_ALERT: begin
        if (alert_cnt_r == 4'h1) begin
          state_nxt = persist_r ? ST_CHECK : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!status_r) begin
          state_nxt = ST_CHECK;
        end
      end
      default: state_nxt = ST_CHECK;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r <= ST_CHECK;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // pulse covers the queue drain plus the minimum width
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      alert_cnt_r <= 4'h0;
    end else if (ce) begin
      if (par_err) begin
        alert_cnt_r <= ALERT_PW + pl_clks;
      end else if (alert_cnt_r != 4'h0) begin
        alert_cnt_r <= alert_cnt_r - 4'h1;
      end
    end
  end

  // once the queue is empty all banks close
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      precharge_all    <= 1'b0;
      power_down_entry <= 1'b0;
    end else if (ce) begin
      precharge_all    <= state_r == ST_ALERT
                       && alert_cnt_r == ALERT_PW;
      power_down_entry <= par_err && cmd_sre;
    end
  end

  assign alert_n = !(state_r == ST_ALERT);
  assign checking = state_r == ST_CHECK;

  //**********************************************************
  // latencies
  //**********************************************************
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      write_latency     <= 7'h00;
      read_latency      <= 7'h00;
      parity_mode_delay <= `BASE_MOD_CLKS;
    end else if (ce) begin
      write_latency <= 7'(additive_latency) + 7'(write_cas_latency)
                     + 7'(pl_clks);
      read_latency  <= 7'(additive_latency) + 7'(read_cas_latency)
                     + 7'(pl_clks);
      parity_mode_delay <= `BASE_MOD_CLKS + 8'((pl_r != `PL_OFF)
                         ? pl_clks : pl_clocks(pl_prev_r));
    end
  end

  assign parity_error_status = status_r;
  assign parity_latency      = pl_r;

endmodule
`default_nettype wire

/* File: rtl/ca_parity_defines.svh */
/*
 * Constants of the command/address parity checker and error log:
 * mode register selects and fields, latency codes and timing.
 * Assumes a 50 MHz clk_sys; included by the package and the main module.
 */
// Contract
// - commands delayed by parity_latency; 000 off, else 4/5/6/8 clocks.
// - parity_latency adds to write and read latency.
// - non-persistent: latency stays, checking stops until status cleared.
// - persistent mode (mode_register_five A9) rechecks after alert ends.
// - persistent mode pulses alert within the pulse width limits per error.
// - non-persistent error: drain, precharge all, checking off till cleared.
// - persistent error: drain, precharge all, checking back by pulse end.
// - errant self_refresh_entry masked; precharge power-down instead.
// - entry uses new latency, exit uses latency before the exit command.
// - error log readable in readout page 1 only with mode_register_three A2.
// - log in four bytes: address, high address, bank/control, status.
// - even parity over act, ras, cas, we, bank group, bank, address, par.
// - selected errant command ignored, logged, status set, alert driven low.
`ifndef CA_PARITY_DEFINES_SVH
`define CA_PARITY_DEFINES_SVH

// mode register select {bg0, ba1, ba0}
`define MR_SEL_THREE      3'h3
`define MR_SEL_FIVE       3'h5
// mode_register_five fields
`define MR5_PL_LSB        0
`define MR5_STATUS_BIT    4
`define MR5_PERSIST_BIT   9
// mode_register_three fields
`define MR3_PAGE_LSB      0
`define MR3_READOUT_BIT   2
`define READOUT_PAGE_LOG  2'h1
// parity latency codes
`define PL_OFF            3'h0
`define PL_4              3'h1
`define PL_5              3'h2
`define PL_6              3'h3
`define PL_8              3'h4
`define PL_MAX_CLKS       4'h8
// timing
`define CLK_PERIOD_NS     20
`define ALERT_PW_MIN_NS   80
`define ALERT_PW_CYC ((`ALERT_PW_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BASE_MOD_CLKS     8'h18

`endif

/* File: rtl/ca_parity_pkg.sv */
/*
 * Types and shared decode of the parity checker.
 * Assumes ca_parity_defines.svh is on the include path.
 */
`include "ca_parity_defines.svh"
`default_nettype none
package ca_parity_pkg;

  typedef struct packed {
    logic        par;
    logic        act_n;
    logic        ras;
    logic        cas;
    logic        we;
    logic [1:0]  bg;
    logic [1:0]  ba;
    logic        a17;
    logic [13:0] addr;
    logic [2:0]  cid;
  } frame_t;

  typedef enum logic [1:0] {
    ST_CHECK = 2'b00,
    ST_ALERT = 2'b01,
    ST_HOLD  = 2'b11
  } chk_state_t;

  function automatic logic [3:0] pl_clocks(input logic [2:0] code);
    case (code)
      `PL_4:   pl_clocks = 4'h4;
      `PL_5:   pl_clocks = 4'h5;
      `PL_6:   pl_clocks = 4'h6;
      `PL_8:   pl_clocks = 4'h8;
      default: pl_clocks = 4'h0;
    endcase
  endfunction

endpackage
`default_nettype wire
